// file: src/vts_consts.vh
`ifndef VTS_CONSTS_VH
`define VTS_CONSTS_VH
// Register word offsets (byte addresses)
`define VTS_ADDR_MODE      8'h00
`define VTS_ADDR_URES      8'h04
`define VTS_ADDR_IRES      8'h08
`define VTS_ADDR_UNEG      8'h0C
`define VTS_ADDR_INEG      8'h10
`define VTS_ADDR_DLU       8'h14
`define VTS_ADDR_DLI       8'h18
`define VTS_ADDR_CTRL      8'h1C
`define VTS_ADDR_STATUS    8'h20
`define VTS_ADDR_IRQST     8'h24
`define VTS_ADDR_IRQMASK   8'h28
// Operation modes
`define VTS_MODE_OFF       2'h0
`define VTS_MODE_ZERO      2'h1
`define VTS_MODE_NEG       2'h2
`define VTS_MODE_SPECIAL   2'h3
// Setting ranges and defaults, in percent
`define VTS_URES_MIN       7'h05
`define VTS_URES_MAX       7'h32
`define VTS_URES_DEF       7'h1E
`define VTS_IRES_MIN       7'h0A
`define VTS_IRES_MAX       7'h32
`define VTS_IRES_DEF       7'h0A
`define VTS_UNEG_MIN       7'h05
`define VTS_UNEG_MAX       7'h32
`define VTS_UNEG_DEF       7'h0A
`define VTS_INEG_MIN       7'h0A
`define VTS_INEG_MAX       7'h32
`define VTS_INEG_DEF       7'h0A
`define VTS_DLU_MIN        7'h0A
`define VTS_DLU_MAX        7'h64
`define VTS_DLU_DEF        7'h3C
`define VTS_DLI_MIN        7'h02
`define VTS_DLI_MAX        7'h64
`define VTS_DLI_DEF        7'h0A
// Control register fields and reset value
`define VTS_CTRL_DLDEN_BIT 0
`define VTS_CTRL_DEF       1'h1
// Status and interrupt bit positions
`define VTS_ST_FAIL_BIT    0
`define VTS_ST_DEAD_BIT    1
`define VTS_ST_LOK_BIT     2
// Reset ratio 0.95 expressed as 19/20
`define VTS_RR_NUM         5'h13
`define VTS_RR_DEN         5'h14
// Operate time bound 20 ms at 200 MHz, longest time rounds down
`define VTS_OPTIME_NS      20000000
`define VTS_CLK_NS         5
`define VTS_OPTIME_CYC     (`VTS_OPTIME_NS / `VTS_CLK_NS)
`endif

// file: src/vts_supervision.v
// Operation
// - Zero mode: fail when residual voltage high and residual current low.
// - Negative mode: fail when negative voltage high and negative current low.
// - Special: residual voltage high, residual and negative currents both low.
// - Mode selector off/zero/neg/special, default zero; off never fails.
// - Residual voltage threshold 5 to 50 percent, default 30.
// - Current thresholds 10 to 50, negative voltage 5 to 50, default 10.
// - Supervise only while dead line detection is enabled and unblocked.
// - Block input disables supervision; failure flag stays low meanwhile.
// - Internal failure condition feeds the decision stage only.
// - Decision stage drives dead line, line OK and failure flags.
// - Six per-phase start flags enter the decision stage.
// - Failure asserts well under 20 ms; comparisons release at 0.95.
// - Dead line voltage 10 to 100 default 60, current 2 to 100 default 10.
// - Dead line when all voltages and all currents are below threshold.
// - Line OK when all three phase voltages exceed the threshold.
`timescale 1ns/1ps
`default_nettype none
`include "vts_consts.vh"

// Threshold comparator with hysteresis; level in percent, magnitude in 1/256 percent of nominal
module vts_cmp (
   input  wire       clk,
   input  wire       rstN,
   input  wire       sample,
   input  wire [6:0] level,
   input  wire [15:0] mag,
   output reg        over
);
   wire [22:0] magScaled;
   wire [22:0] opLevel;
   wire [22:0] relLevel;

   // Magnitude in 1/256 percent units compared against operate and release levels
   assign magScaled = {7'h00, mag} * 23'h000014;
   assign opLevel   = {16'h0000, level} * 23'h001400;
   assign relLevel  = {16'h0000, level} * 23'h001300;

   // Pick up above operate level, drop out below 0.95 of it
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         over <= 1'b0;
      end else if (sample) begin
         if (magScaled > opLevel)
            over <= 1'b1;
         else if (magScaled < relLevel)
            over <= 1'b0;
      end
   end
endmodule // vts_cmp

// Percent setting register; clamps writes into range, restores default on reset
module vts_setting #(
   parameter [7:0] ADDR = 8'h00,
   parameter [6:0] DEF  = 7'h00,
   parameter [6:0] MIN  = 7'h00,
   parameter [6:0] MAX  = 7'h7F
) (
   input  wire       clk,
   input  wire       rstN,
   input  wire       wr,
   input  wire [7:0] addr,
   input  wire [6:0] wdata,
   output reg  [6:0] value
);
   reg  [6:0] clamped;

   // Out of range writes land on the nearest limit, never on an illegal level
   always @* begin
      if (wdata < MIN)
         clamped = MIN;
      else if (wdata > MAX)
         clamped = MAX;
      else
         clamped = wdata;
   end

   // Only a write to this register's own offset changes it
   always @(posedge clk or negedge rstN) begin
      if (!rstN)
         value <= DEF;
      else if (wr && addr == ADDR)
         value <= clamped;
   end
endmodule // vts_setting

module vts_supervision (
   input  wire        clk,
   input  wire        rst_n,
   input  wire [7:0]  regAddr,
   input  wire [31:0] regWdata,
   input  wire        regWr,
   input  wire        regRd,
   output reg  [31:0] regRdata,
   input  wire        measStrobe,
   input  wire [15:0] residualVoltageMag,
   input  wire [15:0] residualCurrentMag,
   input  wire [15:0] negseqVoltageMag,
   input  wire [15:0] negseqCurrentMag,
   input  wire        phase1VoltageStart,
   input  wire        phase2VoltageStart,
   input  wire        phase3VoltageStart,
   input  wire        phase1CurrentStart,
   input  wire        phase2CurrentStart,
   input  wire        phase3CurrentStart,
   input  wire        deadlineBlockInput,
   input  wire        supervisionBlockInput,
   output reg         vtFailureFlag,
   output reg         deadLineFlag,
   output reg         lineOkFlag,
   output wire        irq
);
   reg        rstMeta;
   reg        rstSync;
   reg  [1:0] blkMeta;
   reg  [1:0] blkSync;
   reg  [5:0] startMeta;
   reg  [5:0] startSync;
   reg  [1:0] supervisionModeSelect;
   wire [6:0] residualVoltageThreshold;
   wire [6:0] residualCurrentThreshold;
   wire [6:0] negseqVoltageThreshold;
   wire [6:0] negseqCurrentThreshold;
   wire [6:0] deadlineVoltageThreshold;
   wire [6:0] deadlineCurrentThreshold;
   reg        deadlineEnable;
   reg  [2:0] irqStatus;
   reg  [2:0] irqMask;
   reg  [2:0] prevFlags;
   reg        internalFailureCondition;
   reg        next_internalFailureCondition;
   wire       uResOver;
   wire       iResOver;
   wire       uNegOver;
   wire       iNegOver;
   wire       dldOperable;
   wire       vtsActive;
   wire [2:0] flagRise;
   wire [2:0] w1c;

   // Reset release through two flops
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   // Two-flop synchronisers for external status bits
   always @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         blkMeta   <= 2'h0;
         blkSync   <= 2'h0;
         startMeta <= 6'h00;
         startSync <= 6'h00;
      end else begin
         blkMeta   <= {supervisionBlockInput, deadlineBlockInput};
         blkSync   <= blkMeta;
         startMeta <= {phase3CurrentStart, phase2CurrentStart, phase1CurrentStart,
                       phase3VoltageStart, phase2VoltageStart, phase1VoltageStart};
         startSync <= startMeta;
      end
   end

   // Comparators for the four sequence quantities
   vts_cmp uCmpURes (.clk(clk), .rstN(rstSync), .sample(measStrobe),
                     .level(residualVoltageThreshold), .mag(residualVoltageMag), .over(uResOver));
   vts_cmp uCmpIRes (.clk(clk), .rstN(rstSync), .sample(measStrobe),
                     .level(residualCurrentThreshold), .mag(residualCurrentMag), .over(iResOver));
   vts_cmp uCmpUNeg (.clk(clk), .rstN(rstSync), .sample(measStrobe),
                     .level(negseqVoltageThreshold), .mag(negseqVoltageMag), .over(uNegOver));
   vts_cmp uCmpINeg (.clk(clk), .rstN(rstSync), .sample(measStrobe),
                     .level(negseqCurrentThreshold), .mag(negseqCurrentMag), .over(iNegOver));

   assign dldOperable = deadlineEnable & ~blkSync[0];
   assign vtsActive   = dldOperable & ~blkSync[1];

   // Mode dependent failure criterion
   always @* begin
      case (supervisionModeSelect)
         `VTS_MODE_ZERO:    next_internalFailureCondition = uResOver & ~iResOver;
         `VTS_MODE_NEG:     next_internalFailureCondition = uNegOver & ~iNegOver;
         `VTS_MODE_SPECIAL: next_internalFailureCondition =
                               uResOver & ~iResOver & ~iNegOver;
         default:           next_internalFailureCondition = 1'b0;
      endcase
   end

   // Internal condition, kept off the register map
   always @(posedge clk or negedge rstSync) begin
      if (!rstSync)
         internalFailureCondition <= 1'b0;
      else
         internalFailureCondition <= next_internalFailureCondition & vtsActive;
   end

   // Decision stage outputs, failure flag one cycle after the condition, line flags one cycle after the synchronised starts
   always @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         vtFailureFlag <= 1'b0;
         deadLineFlag  <= 1'b0;
         lineOkFlag    <= 1'b0;
      end else begin
         vtFailureFlag <= internalFailureCondition & vtsActive;
         deadLineFlag  <= dldOperable & ~(|startSync);
         lineOkFlag    <= dldOperable & (&startSync[2:0]);
      end
   end

   // Mode, control and mask registers; percent settings live in their own cells
   always @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         supervisionModeSelect    <= `VTS_MODE_ZERO;
         deadlineEnable           <= `VTS_CTRL_DEF;
         irqMask                  <= 3'h0;
      end else if (regWr) begin
         case (regAddr)
            `VTS_ADDR_MODE: supervisionModeSelect <= regWdata[1:0];
            `VTS_ADDR_CTRL: deadlineEnable <= regWdata[`VTS_CTRL_DLDEN_BIT];
            `VTS_ADDR_IRQMASK: irqMask <= regWdata[2:0];
            default: ;
         endcase
      end
   end

   // Percent settings, each clamped into its own range on write
   vts_setting #(
      .ADDR(`VTS_ADDR_URES),
      .DEF (`VTS_URES_DEF),
      .MIN (`VTS_URES_MIN),
      .MAX (`VTS_URES_MAX)
   ) uSetURes (
      .clk  (clk),
      .rstN (rstSync),
      .wr   (regWr),
      .addr (regAddr),
      .wdata(regWdata[6:0]),
      .value(residualVoltageThreshold)
   );
   vts_setting #(
      .ADDR(`VTS_ADDR_IRES),
      .DEF (`VTS_IRES_DEF),
      .MIN (`VTS_IRES_MIN),
      .MAX (`VTS_IRES_MAX)
   ) uSetIRes (
      .clk  (clk),
      .rstN (rstSync),
      .wr   (regWr),
      .addr (regAddr),
      .wdata(regWdata[6:0]),
      .value(residualCurrentThreshold)
   );
   vts_setting #(
      .ADDR(`VTS_ADDR_UNEG),
      .DEF (`VTS_UNEG_DEF),
      .MIN (`VTS_UNEG_MIN),
      .MAX (`VTS_UNEG_MAX)
   ) uSetUNeg (
      .clk  (clk),
      .rstN (rstSync),
      .wr   (regWr),
      .addr (regAddr),
      .wdata(regWdata[6:0]),
      .value(negseqVoltageThreshold)
   );
   vts_setting #(
      .ADDR(`VTS_ADDR_INEG),
      .DEF (`VTS_INEG_DEF),
      .MIN (`VTS_INEG_MIN),
      .MAX (`VTS_INEG_MAX)
   ) uSetINeg (
      .clk  (clk),
      .rstN (rstSync),
      .wr   (regWr),
      .addr (regAddr),
      .wdata(regWdata[6:0]),
      .value(negseqCurrentThreshold)
   );
   vts_setting #(
      .ADDR(`VTS_ADDR_DLU),
      .DEF (`VTS_DLU_DEF),
      .MIN (`VTS_DLU_MIN),
      .MAX (`VTS_DLU_MAX)
   ) uSetDlu (
      .clk  (clk),
      .rstN (rstSync),
      .wr   (regWr),
      .addr (regAddr),
      .wdata(regWdata[6:0]),
      .value(deadlineVoltageThreshold)
   );
   vts_setting #(
      .ADDR(`VTS_ADDR_DLI),
      .DEF (`VTS_DLI_DEF),
      .MIN (`VTS_DLI_MIN),
      .MAX (`VTS_DLI_MAX)
   ) uSetDli (
      .clk  (clk),
      .rstN (rstSync),
      .wr   (regWr),
      .addr (regAddr),
      .wdata(regWdata[6:0]),
      .value(deadlineCurrentThreshold)
   );

   // Sticky interrupt bits on each flag rising; set wins over write-one clear
   assign flagRise = {lineOkFlag, deadLineFlag, vtFailureFlag} & ~prevFlags;
   assign w1c      = (regWr && regAddr == `VTS_ADDR_IRQST) ? regWdata[2:0] : 3'h0;
   always @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         prevFlags <= 3'h0;
         irqStatus <= 3'h0;
      end else begin
         prevFlags <= {lineOkFlag, deadLineFlag, vtFailureFlag};
         irqStatus <= (irqStatus & ~w1c) | flagRise;
      end
   end

   assign irq = |(irqStatus & irqMask);

   // Read data one cycle after the read strobe, zero otherwise
   always @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         regRdata <= 32'h00000000;
      end else if (regRd) begin
         case (regAddr)
            `VTS_ADDR_MODE:    regRdata <= {30'h00000000, supervisionModeSelect};
            `VTS_ADDR_URES:    regRdata <= {25'h0000000, residualVoltageThreshold};
            `VTS_ADDR_IRES:    regRdata <= {25'h0000000, residualCurrentThreshold};
            `VTS_ADDR_UNEG:    regRdata <= {25'h0000000, negseqVoltageThreshold};
            `VTS_ADDR_INEG:    regRdata <= {25'h0000000, negseqCurrentThreshold};
            `VTS_ADDR_DLU:     regRdata <= {25'h0000000, deadlineVoltageThreshold};
            `VTS_ADDR_DLI:     regRdata <= {25'h0000000, deadlineCurrentThreshold};
            `VTS_ADDR_CTRL:    regRdata <= {31'h00000000, deadlineEnable};
            `VTS_ADDR_STATUS:  regRdata <= {29'h00000000, lineOkFlag, deadLineFlag,
                                            vtFailureFlag};
            `VTS_ADDR_IRQST:   regRdata <= {29'h00000000, irqStatus};
            `VTS_ADDR_IRQMASK: regRdata <= {29'h00000000, irqMask};
            default:           regRdata <= 32'h00000000;
         endcase
      end else begin
         regRdata <= 32'h00000000;
      end
   end
endmodule // vts_supervision
`default_nettype wire

// file: testbench/vts_supervision_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module vts_supervision_assertions (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        regRd,
   input wire logic [31:0] regRdata,
   input wire logic        phase1VoltageStart,
   input wire logic        phase2VoltageStart,
   input wire logic        phase3VoltageStart,
   input wire logic        phase1CurrentStart,
   input wire logic        phase2CurrentStart,
   input wire logic        phase3CurrentStart,
   input wire logic        deadlineBlockInput,
   input wire logic        supervisionBlockInput,
   input wire logic        vtFailureFlag,
   input wire logic        deadLineFlag,
   input wire logic        lineOkFlag,
   input wire logic        irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Outputs start low after reset
   reset_out_low_a: assert property ($rose(rst_n) |-> !vtFailureFlag && !deadLineFlag && !lineOkFlag && !irq)
      else $error("output high after reset");
   sup_block_low_a: assert property (supervisionBlockInput [*5] |-> !vtFailureFlag)
      else $error("failure flag while blocked");
   dld_block_fail_a: assert property (deadlineBlockInput [*5] |-> !vtFailureFlag)
      else $error("failure flag while dead line stage blocked");
   dld_block_line_a: assert property (deadlineBlockInput [*5] |-> !deadLineFlag && !lineOkFlag)
      else $error("line flag while dead line stage blocked");
   dead_any_start_a: assert property ((phase1CurrentStart || phase2CurrentStart
      || phase3CurrentStart || phase1VoltageStart || phase2VoltageStart
      || phase3VoltageStart) [*5] |-> !deadLineFlag)
      else $error("dead line with a phase started");
   ok_needs_volt_a: assert property ((!phase1VoltageStart || !phase2VoltageStart
      || !phase3VoltageStart) [*5] |-> !lineOkFlag)
      else $error("line ok without all voltages");
   dead_ok_excl_a: assert property (!(deadLineFlag && lineOkFlag))
      else $error("dead line and line ok together");
   read_idle_zero_a: assert property (!$past(regRd) |-> regRdata == 32'h0)
      else $error("read data outside a read cycle");
endmodule // vts_supervision_assertions
bind vts_supervision vts_supervision_assertions u_vts_supervision_assertions (.clk(clk),
   .rst_n(rst_n), .regRd(regRd), .regRdata(regRdata),
   .phase1VoltageStart(phase1VoltageStart), .phase2VoltageStart(phase2VoltageStart),
   .phase3VoltageStart(phase3VoltageStart), .phase1CurrentStart(phase1CurrentStart),
   .phase2CurrentStart(phase2CurrentStart), .phase3CurrentStart(phase3CurrentStart),
   .deadlineBlockInput(deadlineBlockInput), .supervisionBlockInput(supervisionBlockInput),
   .vtFailureFlag(vtFailureFlag), .deadLineFlag(deadLineFlag), .lineOkFlag(lineOkFlag),
   .irq(irq));
`default_nettype wire

// file: testbench/vts_meas_src.sv
`timescale 1ns/1ps
`default_nettype none
module vts_meas_src (
   input  wire logic        clk,
   output var  logic        measStrobe,
   output var  logic [15:0] uRes,
   output var  logic [15:0] iRes,
   output var  logic [15:0] uNeg,
   output var  logic [15:0] iNeg,
   output var  logic [2:0]  vStart,
   output var  logic [2:0]  cStart
);
   // Idle: no strobe, all phases dead
   initial begin
      measStrobe = 1'b0;
      {uRes, iRes, uNeg, iNeg} = 64'h0;
      {vStart, cStart} = 6'h00;
   end
   // One measurement cycle, magnitudes in percent of nominal, 256 per percent
   task automatic send(input int u, i, un, in);
      @(posedge clk);
      {uRes, iRes, uNeg, iNeg} <= {16'(u * 256), 16'(i * 256), 16'(un * 256), 16'(in * 256)};
      measStrobe <= 1'b1;
      @(posedge clk);
      measStrobe <= 1'b0;
      {uRes, iRes, uNeg, iNeg} <= ~{uRes, iRes, uNeg, iNeg}; // Stale once strobe drops
   endtask
   // Six per-phase start flags
   task automatic starts(input logic [2:0] v, c);
      @(posedge clk);
      {vStart, cStart} <= {v, c};
   endtask
endmodule // vts_meas_src
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "vts_consts.vh"
module tb;
   logic        clk, rst_n, regWr, regRd, measStrobe, dlBlk, supBlk, fail, dead, lok, irq;
   logic [7:0]  regAddr;
   logic [31:0] regWdata, regRdata, v;
   logic [15:0] uRes, iRes, uNeg, iNeg;
   logic [2:0]  vStart, cStart;
   int          miscompares, checked, cycles;
   vts_meas_src u_vts_meas_src (.clk(clk), .measStrobe(measStrobe), .uRes(uRes), .iRes(iRes),
      .uNeg(uNeg), .iNeg(iNeg), .vStart(vStart), .cStart(cStart));
   vts_supervision u_vts_supervision (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .measStrobe(measStrobe), .residualVoltageMag(uRes), .residualCurrentMag(iRes),
      .negseqVoltageMag(uNeg), .negseqCurrentMag(iNeg), .phase1VoltageStart(vStart[0]),
      .phase2VoltageStart(vStart[1]), .phase3VoltageStart(vStart[2]),
      .phase1CurrentStart(cStart[0]), .phase2CurrentStart(cStart[1]),
      .phase3CurrentStart(cStart[2]), .deadlineBlockInput(dlBlk),
      .supervisionBlockInput(supBlk), .vtFailureFlag(fail), .deadLineFlag(dead),
      .lineOkFlag(lok), .irq(irq));
   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input string n, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {regAddr, regWdata, regWr} <= {a, d, 1'b1};
      @(posedge clk);
      regWr <= 1'b0;
      #1;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      {regAddr, regRd} <= {a, 1'b1};
      @(posedge clk);
      regRd <= 1'b0;
      #1 v = regRdata;
      chk($sformatf("reg %h", a), v, e);
   endtask
   task automatic w6;
      repeat (6) @(posedge clk);
      #1;
   endtask
   // One mode and measurement case, then the failure flag
   task automatic cs(input logic [1:0] m, input int u, i, un, in, input logic e);
      wr(`VTS_ADDR_MODE, {30'h0, m});
      u_vts_meas_src.send(u, i, un, in);
      w6;
      chk("fail", fail, e);
   endtask
   task automatic dl(input logic [2:0] vs, cv, input logic ed, el);
      u_vts_meas_src.starts(vs, cv);
      w6;
      chk("dead", dead, ed);
      chk("lineok", lok, el);
   endtask
   task automatic t_defaults;
      rdc(`VTS_ADDR_MODE, 32'h1);
      rdc(`VTS_ADDR_URES, 32'h1E);
      rdc(`VTS_ADDR_IRES, 32'h0A);
      rdc(`VTS_ADDR_UNEG, 32'h0A);
      rdc(`VTS_ADDR_INEG, 32'h0A);
      rdc(`VTS_ADDR_DLU, 32'h3C);
      rdc(`VTS_ADDR_DLI, 32'h0A);
      rdc(`VTS_ADDR_CTRL, 32'h1);
      rdc(`VTS_ADDR_IRQMASK, 32'h0);
      rdc(8'h2C, 32'h0);
   endtask
   task automatic t_clamp;
      wr(`VTS_ADDR_URES, 32'h0);
      rdc(`VTS_ADDR_URES, 32'h05);
      wr(`VTS_ADDR_URES, 32'h7F);
      rdc(`VTS_ADDR_URES, 32'h32);
      wr(`VTS_ADDR_INEG, 32'h0);
      rdc(`VTS_ADDR_INEG, 32'h0A);
      wr(`VTS_ADDR_UNEG, 32'h0);
      rdc(`VTS_ADDR_UNEG, 32'h05);
      wr(`VTS_ADDR_DLU, 32'h7F);
      rdc(`VTS_ADDR_DLU, 32'h64);
      wr(`VTS_ADDR_DLI, 32'h0);
      rdc(`VTS_ADDR_DLI, 32'h02);
      wr(`VTS_ADDR_URES, 32'h1E);
   endtask
   task automatic t_modes;
      cs(2'h0, 40, 5, 40, 5, 1'b0);
      cs(2'h1, 40, 5, 0, 50, 1'b1);
      cs(2'h1, 40, 20, 40, 5, 1'b0);
      cs(2'h1, 20, 5, 40, 5, 1'b0);
      cs(2'h2, 0, 50, 40, 5, 1'b1);
      cs(2'h2, 40, 5, 40, 20, 1'b0);
      cs(2'h3, 40, 5, 0, 5, 1'b1);
      cs(2'h3, 40, 5, 0, 20, 1'b0);
      cs(2'h3, 40, 20, 0, 5, 1'b0);
      cs(2'h1, 40, 5, 0, 0, 1'b1);
      cs(2'h1, 29, 5, 0, 0, 1'b1);
      cs(2'h1, 28, 5, 0, 0, 1'b0);
      cs(2'h1, 30, 5, 0, 0, 1'b0);
   endtask
   task automatic t_block;
      cs(2'h1, 40, 5, 0, 0, 1'b1);
      @(posedge clk) supBlk <= 1'b1;
      w6;
      chk("fail", fail, 1'b0);
      @(posedge clk) supBlk <= 1'b0;
      cs(2'h1, 40, 5, 0, 0, 1'b1);
      @(posedge clk) dlBlk <= 1'b1;
      w6;
      chk("fail", fail, 1'b0);
      @(posedge clk) dlBlk <= 1'b0;
      wr(`VTS_ADDR_CTRL, 32'h0);
      cs(2'h1, 40, 5, 0, 0, 1'b0);
      wr(`VTS_ADDR_CTRL, 32'h1);
      cs(2'h1, 40, 5, 0, 0, 1'b1);
   endtask
   task automatic t_irq;
      cs(2'h1, 0, 5, 0, 0, 1'b0);
      rdc(`VTS_ADDR_IRQST, 32'h7);
      wr(`VTS_ADDR_IRQST, 32'h7);
      rdc(`VTS_ADDR_IRQST, 32'h0);
      cs(2'h1, 40, 5, 0, 0, 1'b1);
      rdc(`VTS_ADDR_IRQST, 32'h1);
      chk("irq", irq, 1'b0);
      wr(`VTS_ADDR_IRQMASK, 32'h1);
      chk("irq", irq, 1'b1);
      wr(`VTS_ADDR_IRQMASK, 32'h0);
      chk("irq", irq, 1'b0);
      wr(`VTS_ADDR_IRQMASK, 32'h1);
      wr(`VTS_ADDR_IRQST, 32'h1);
      chk("irq", irq, 1'b0);
      rdc(`VTS_ADDR_STATUS, 32'h5);
   endtask
   task automatic end_of_test;
      if (miscompares == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         miscompares++;
         end_of_test;
      end
   end
   initial begin
      {rst_n, regWr, regRd, dlBlk, supBlk, regAddr, regWdata} = 45'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_defaults;
      t_clamp;
      t_modes;
      dl(3'h0, 3'h0, 1'b1, 1'b0);
      dl(3'h7, 3'h0, 1'b0, 1'b1);
      dl(3'h3, 3'h0, 1'b0, 1'b0);
      dl(3'h0, 3'h4, 1'b0, 1'b0);
      dl(3'h7, 3'h7, 1'b0, 1'b1);
      t_block;
      t_irq;
      end_of_test;
   end
endmodule // tb
`default_nettype wire
